// ==== verilog/plgc_pkg.sv ====
// Constants of the link general control register block.
// What this block does
// - Bit 31 set switches link timeout off.
// - Bit 30 reports self test passed.
// - Bit 29 forces light-sleep training good.
// - Bit 28 masks running-disparity errors.
// - Bit 27 uncouples deep sleep from receive.
// - Field 26:25 selects idle time, default 4 ms.
// - Latency field loads from nonvolatile memory, read-only.
// - Bit 24 selects entry latency, full or quarter.
// - Wide variant adds bit 23 as latency MSB.
package plgc_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [15:0] PLGC_GCTL_OFS = 16'h5b00;
  localparam int PLGC_ADDR_W = 16;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int PLGC_TMO_DIS_BIT = 31;
  localparam int PLGC_SELFTEST_BIT = 30;
  localparam int PLGC_FGOOD_BIT = 29;
  localparam int PLGC_DISP_BIT = 28;
  localparam int PLGC_UNCORR_BIT = 27;
  localparam int PLGC_LAT_HI_BIT = 26;
  localparam int PLGC_LAT_LO_BIT = 25;
  localparam int PLGC_RATIO_BIT = 24;
  localparam int PLGC_LAT_MSB_BIT = 23;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] PLGC_LAT_RST = 2'h3;
  localparam logic PLGC_LAT_MSB_RST = 1'b1;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int PLGC_CLK_MHZ = 50;
  localparam int PLGC_T2_US = 2;
  localparam int PLGC_T8_US = 8;
  localparam int PLGC_T16_US = 16;
  localparam int PLGC_T32_US = 32;
  localparam int PLGC_T64_US = 64;
  localparam int PLGC_T256_US = 256;
  localparam int PLGC_T1_MS = 1;
  localparam int PLGC_T4_MS = 4;
  localparam int PLGC_C2 = PLGC_T2_US * PLGC_CLK_MHZ;
  localparam int PLGC_C8 = PLGC_T8_US * PLGC_CLK_MHZ;
  localparam int PLGC_C16 = PLGC_T16_US * PLGC_CLK_MHZ;
  localparam int PLGC_C32 = PLGC_T32_US * PLGC_CLK_MHZ;
  localparam int PLGC_C64 = PLGC_T64_US * PLGC_CLK_MHZ;
  localparam int PLGC_C256 = PLGC_T256_US * PLGC_CLK_MHZ;
  localparam int PLGC_C1M = PLGC_T1_MS * 1000 * PLGC_CLK_MHZ;
  localparam int PLGC_C4M = PLGC_T4_MS * 1000 * PLGC_CLK_MHZ;
  localparam int PLGC_CNT_W = 18;

  // ------------------------------------------------------------------
  // AHB encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] PLGC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] PLGC_HTRANS_SEQ = 2'h3;

endpackage

// ==== verilog/plgc_sync.sv ====
// Two-stage synchroniser for link status levels.
`timescale 1ns/1ps
`default_nettype none
module plgc_sync #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } plgc_sync_st_t;

  plgc_sync_st_t st_r;
  plgc_sync_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule
`default_nettype wire

// ==== verilog/plgc_idle_timer.sv ====
// Idle timer that counts time spent in light sleep.
`timescale 1ns/1ps
`default_nettype none
module plgc_idle_timer #(
  parameter int CNT_W = 18
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic idle,
  input wire logic [CNT_W-1:0] limit,
  output logic expired
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic expired;
  } plgc_tmr_st_t;

  plgc_tmr_st_t st_r;
  plgc_tmr_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (!idle) begin
      st_nxt.cnt = '0;
      st_nxt.expired = 1'b0;
    end else if (st_r.cnt >= limit - 1'b1) begin
      st_nxt.expired = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;

endmodule
`default_nettype wire

// ==== verilog/plgc_top.sv ====
// Link general control register with AHB-Lite access and idle timing.
`timescale 1ns/1ps
`default_nettype none
module plgc_top #(
  parameter bit WIDE_LATENCY = 1'b1,
  parameter bit UNCORR_SUPPORTED = 1'b1,
  parameter int CYC_256US = plgc_pkg::PLGC_C256,
  parameter int CYC_1MS = plgc_pkg::PLGC_C1M,
  parameter int CYC_4MS = plgc_pkg::PLGC_C4M,
  parameter int LAT_W = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic selftest_pass,
  input wire logic nvm_load,
  input wire logic [2:0] nvm_latency,
  input wire logic link_tx_l0s,
  input wire logic link_rx_l0s,
  input wire logic [LAT_W-1:0] light_sleep_exit_latency,
  output logic timeout_enable,
  output logic force_good_lowpower_training,
  output logic disparity_error_mask,
  output logic deep_sleep_uncorrelated,
  output logic [LAT_W-1:0] light_sleep_entry_latency,
  output logic deep_sleep_request
);
  import plgc_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic tmo_dis;
    logic selftest_ok;
    logic fgood;
    logic disp_mask;
    logic uncorr;
    logic [1:0] lat;
    logic ratio;
    logic lat_msb;
    logic wr_pend;
    logic [31:0] rdata;
    logic ready;
    logic timeout_en;
    logic [LAT_W-1:0] entry_lat;
    logic l1_req;
  } plgc_top_st_t;

  plgc_top_st_t st_r;
  plgc_top_st_t st_nxt;

  logic [1:0] link_sync;
  logic idle_now;
  logic timer_expired;
  logic [2:0] lat_code;
  logic [PLGC_CNT_W-1:0] lat_limit;
  logic addr_hit;
  logic addr_phase;
  logic [31:0] reg_view;

  // ------------------------------------------------------------------
  // Link status synchronisers
  // ------------------------------------------------------------------
  plgc_sync #(
    .W(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in({link_rx_l0s, link_tx_l0s}),
    .sync_out(link_sync)
  );

  // ------------------------------------------------------------------
  // Latency selection
  // ------------------------------------------------------------------
  // wide code MSB
  assign lat_code = {(WIDE_LATENCY ? st_r.lat_msb : 1'b1), st_r.lat};

  always_comb begin
    case (lat_code)
      3'h0: lat_limit = PLGC_CNT_W'(PLGC_C2);
      3'h1: lat_limit = PLGC_CNT_W'(PLGC_C8);
      3'h2: lat_limit = PLGC_CNT_W'(PLGC_C16);
      3'h3: lat_limit = PLGC_CNT_W'(PLGC_C32);
      3'h4: lat_limit = PLGC_CNT_W'(PLGC_C64);
      3'h5: lat_limit = PLGC_CNT_W'(CYC_256US);
      3'h6: lat_limit = PLGC_CNT_W'(CYC_1MS);
      3'h7: lat_limit = PLGC_CNT_W'(CYC_4MS);
      default: lat_limit = PLGC_CNT_W'(CYC_4MS);
    endcase
  end

  // ------------------------------------------------------------------
  // Idle timing
  // ------------------------------------------------------------------
  // receive correlation
  assign idle_now = link_sync[0] & (st_r.uncorr | link_sync[1]);

  plgc_idle_timer #(
    .CNT_W(PLGC_CNT_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .idle(idle_now),
    .limit(lat_limit),
    .expired(timer_expired)
  );

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign addr_phase = hsel & hready & htrans[1];
  assign addr_hit = (haddr[PLGC_ADDR_W-1:0] == PLGC_GCTL_OFS)
                  & (haddr[31:PLGC_ADDR_W] == '0);

  always_comb begin
    reg_view = '0;
    reg_view[PLGC_TMO_DIS_BIT] = st_r.tmo_dis;
    reg_view[PLGC_SELFTEST_BIT] = st_r.selftest_ok;
    reg_view[PLGC_FGOOD_BIT] = st_r.fgood;
    reg_view[PLGC_DISP_BIT] = st_r.disp_mask;
    reg_view[PLGC_UNCORR_BIT] = st_r.uncorr;
    reg_view[PLGC_LAT_HI_BIT] = st_r.lat[1];
    reg_view[PLGC_LAT_LO_BIT] = st_r.lat[0];
    reg_view[PLGC_RATIO_BIT] = st_r.ratio;
    reg_view[PLGC_LAT_MSB_BIT] = WIDE_LATENCY ? st_r.lat_msb : 1'b0;
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = 1'b1;
    st_nxt.wr_pend = addr_phase & hwrite & addr_hit;
    if (addr_phase) begin
      st_nxt.rdata = (!hwrite && addr_hit) ? reg_view : '0;
    end

    if (st_r.wr_pend) begin
      st_nxt.tmo_dis = hwdata[PLGC_TMO_DIS_BIT];
      st_nxt.fgood = hwdata[PLGC_FGOOD_BIT];
      st_nxt.disp_mask = hwdata[PLGC_DISP_BIT];
      st_nxt.uncorr = UNCORR_SUPPORTED & hwdata[PLGC_UNCORR_BIT];
      st_nxt.ratio = hwdata[PLGC_RATIO_BIT];
      if (!hwdata[PLGC_SELFTEST_BIT]) begin
        st_nxt.selftest_ok = 1'b0;
      end
    end

    if (selftest_pass) begin
      st_nxt.selftest_ok = 1'b1;
    end

    if (nvm_load) begin
      st_nxt.lat = nvm_latency[1:0];
      st_nxt.lat_msb = WIDE_LATENCY & nvm_latency[2];
    end

    st_nxt.timeout_en = ~st_r.tmo_dis;

    if (st_r.ratio) begin
      st_nxt.entry_lat = light_sleep_exit_latency >> 2;
    end else begin
      st_nxt.entry_lat = light_sleep_exit_latency;
    end

    st_nxt.l1_req = timer_expired;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
      st_r.ready <= 1'b1;
      st_r.timeout_en <= 1'b1;
      st_r.lat <= PLGC_LAT_RST;
      st_r.lat_msb <= WIDE_LATENCY ? PLGC_LAT_MSB_RST : 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign hreadyout = st_r.ready;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign timeout_enable = st_r.timeout_en;
  assign force_good_lowpower_training = st_r.fgood;
  assign disparity_error_mask = st_r.disp_mask;
  assign deep_sleep_uncorrelated = st_r.uncorr;
  assign light_sleep_entry_latency = st_r.entry_lat;
  assign deep_sleep_request = st_r.l1_req;

endmodule
`default_nettype wire

// ==== bench/plgc_checker.sv ====
// Checker of the link general control block ports.
`timescale 1ns/1ps
`default_nettype none
module plgc_checker import plgc_pkg::*; #(
  parameter int LAT_W = 8
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic link_tx_l0s,
  input wire logic timeout_enable,
  input wire logic force_good_lowpower_training,
  input wire logic disparity_error_mask,
  input wire logic deep_sleep_uncorrelated,
  input wire logic [LAT_W-1:0] light_sleep_exit_latency,
  input wire logic [LAT_W-1:0] light_sleep_entry_latency,
  input wire logic deep_sleep_request
);
  logic wr;
  assign wr = hsel && hready && htrans[1] && hwrite && (haddr == {16'h0, PLGC_GCTL_OFS});
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_TMO: assert property (wr |=> ##2 timeout_enable == !$past(hwdata[31], 2))
    else $error("timeout enable wrong");
  AST_FGOOD: assert property (wr |=> ##1 force_good_lowpower_training == $past(hwdata[29]))
    else $error("force good wrong");
  AST_DISP: assert property (wr |=> ##1 disparity_error_mask == $past(hwdata[28]))
    else $error("disparity mask wrong");
  AST_UNCORR: assert property (wr |=> ##1 deep_sleep_uncorrelated == $past(hwdata[27]))
    else $error("uncorrelated wrong");
  AST_RATIO: assert property (wr |=> ##3 light_sleep_entry_latency == ($past(hwdata[24], 3) ?
    $past(light_sleep_exit_latency) >> 2 : $past(light_sleep_exit_latency)))
    else $error("entry latency wrong");
  AST_IDLE: assert property (!link_tx_l0s [*6] |-> !deep_sleep_request)
    else $error("request without idle");
  AST_RISE: assert property ($rose(deep_sleep_request) |-> $past(link_tx_l0s, 8))
    else $error("request too early");
  AST_RST: assert property (disable iff (1'b0) srst |=> timeout_enable && hrdata == 32'h0)
    else $error("reset state wrong");
endmodule
bind plgc_top plgc_checker #(.LAT_W(LAT_W)) plgc_checker_inst (.*);
`default_nettype wire

// ==== bench/plgc_link_model.sv ====
// Link partner model that drives the asynchronous L0s levels.
`timescale 1ns/1ps
`default_nettype none
module plgc_link_model (
  input wire logic clk_sys,
  input wire logic want_tx,
  input wire logic want_rx,
  output logic link_tx_l0s,
  output logic link_rx_l0s
);
  initial {link_tx_l0s, link_rx_l0s} = 2'b00;
  always @(posedge clk_sys) begin
    #3;
    link_tx_l0s = want_tx;
    link_rx_l0s = want_rx;
  end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking testbench of the link general control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import plgc_pkg::*;
  logic clk_sys, srst, hsel, hwrite, selftest_pass, nvm_load, want_tx, want_rx;
  logic [31:0] haddr, hwdata, r, d, ex;
  logic [1:0] htrans;
  logic [2:0] hsize, nvm_latency;
  logic [7:0] xl;
  wire logic hready, hresp, link_tx, link_rx, toe, fg, dm, du, dsr;
  wire logic [31:0] hrdata;
  wire logic [7:0] el;
  int errors, num_checks, n;
  int lim[8] = '{100, 400, 800, 1600, 3200, 40, 60, 80};
  localparam logic [31:0] RA = {16'h0, PLGC_GCTL_OFS};
  plgc_top #(.CYC_256US(40), .CYC_1MS(60), .CYC_4MS(80)) plgc_top_inst (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .selftest_pass(selftest_pass), .nvm_load(nvm_load),
    .nvm_latency(nvm_latency), .link_tx_l0s(link_tx), .link_rx_l0s(link_rx),
    .light_sleep_exit_latency(xl), .timeout_enable(toe), .force_good_lowpower_training(fg),
    .disparity_error_mask(dm), .deep_sleep_uncorrelated(du), .light_sleep_entry_latency(el),
    .deep_sleep_request(dsr));
  plgc_link_model plgc_link_model_inst (.clk_sys(clk_sys), .want_tx(want_tx),
    .want_rx(want_rx), .link_tx_l0s(link_tx), .link_rx_l0s(link_rx));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task check(input logic [31:0] seen, input logic [31:0] expv);
    num_checks++;
    if (seen !== expv) begin
      errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1; haddr <= a; htrans <= PLGC_HTRANS_NONSEQ; hwrite <= w;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (hready !== 1'b1 && n < 50);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge clk_sys); n++; end while (hready !== 1'b1 && n < 100);
    r = hrdata;
    if (hready !== 1'b1 || hresp !== 1'b0) begin
      errors++;
      $display("ERROR t=%0t bus answer missing or not okay", $time);
    end
    @(posedge clk_sys);
    if (w && a == RA) ex = (ex & 32'h06800000) | (wd & 32'hb9000000) | (ex & wd & 32'h40000000);
  endtask
  task idle_wait;
    n = 0;
    while (dsr !== 1'b1 && n < 4000) begin @(negedge clk_sys); n++; end
    @(posedge clk_sys);
  endtask
  initial begin
    srst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = '0; selftest_pass = 1'b0; nvm_load = 1'b0; nvm_latency = 3'h0;
    want_tx = 1'b0; want_rx = 1'b0;
    void'($urandom(88444));
    xl = 8'($urandom);
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    ex = 32'h06800000;
    ahb(1'b0, RA, 32'h0); check(r, ex);
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      ahb(1'b1, RA, d);
      @(posedge clk_sys); @(negedge clk_sys);
      check({toe, fg, dm, du}, {!d[31], d[29], d[28], d[27]});
      check(32'(el), 32'(d[24] ? xl >> 2 : xl));
      @(posedge clk_sys);
      ahb(1'b0, RA, 32'h0); check(r, ex);
    end
    ahb(1'b1, RA + 32'h4, 32'hffffffff); ahb(1'b0, RA + 32'h4, 32'h0); check(r, 32'h0);
    $display("test registers done");
    selftest_pass <= 1'b1; @(posedge clk_sys); selftest_pass <= 1'b0; ex |= 32'h40000000;
    ahb(1'b0, RA, 32'h0); check(r, ex);
    ahb(1'b1, RA, 32'h0); ahb(1'b0, RA, 32'h0); check(r, ex);
    $display("test self test done");
    for (int c = 0; c < 8; c++) begin
      nvm_latency <= 3'(c); nvm_load <= 1'b1; @(posedge clk_sys); nvm_load <= 1'b0;
      ex = (ex & 32'hf97fffff) | (32'(c & 3) << 25) | (32'(c >> 2) << 23);
      ahb(1'b0, RA, 32'h0); check(r, ex);
      want_tx <= 1'b1; want_rx <= 1'b1; idle_wait;
      check(32'(n >= lim[c] && n <= lim[c] + 6), 32'h1);
      want_tx <= 1'b0; want_rx <= 1'b0; repeat (10) @(posedge clk_sys);
    end
    want_tx <= 1'b1; repeat (100) @(posedge clk_sys); check(32'(dsr), 32'h0);
    ahb(1'b1, RA, 32'h08000000); idle_wait; check(32'(n <= 86), 32'h1);
    want_tx <= 1'b0; repeat (10) @(posedge clk_sys); want_tx <= 1'b1;
    repeat (50) @(posedge clk_sys); want_tx <= 1'b0; repeat (10) @(posedge clk_sys);
    want_tx <= 1'b1; idle_wait; check(32'(n >= 80 && n <= 86), 32'h1);
    $display("test idle timing done");
    complete_run;
  end
  initial begin
    #1000000;
    errors++;
    $display("ERROR t=%0t watchdog expired", $time);
    complete_run;
  end
endmodule
`default_nettype wire
